// >>> rtl/spi_csd.sv
// serial peripheral control, status and data registers with shifter, behind an apb slave
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`include "spi_csd_defs.svh"

module spi_csd
(
    input  wire logic                        core_clk,
    input  wire logic                        rst_b,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [15:0]                 paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic                        cpu_irq_mask,
    output logic                             irq,
    input  wire logic [7:0]                  port_in,
    output spi_csd_pkg::port_drive_type      port_drive
);

    // ****************************************
    // decode and helpers
    // ****************************************
    function automatic spi_csd_pkg::reg_sel_type decode(input logic [15:0] a);
        if (a == `ADDR_OF(`IDX_SERIAL_CONTROL))
            return spi_csd_pkg::sel_control;
        else if (a == `ADDR_OF(`IDX_SERIAL_STATUS))
            return spi_csd_pkg::sel_status;
        else if (a == `ADDR_OF(`IDX_SERIAL_DATA))
            return spi_csd_pkg::sel_data;
        else if (a == `ADDR_OF(`IDX_PORT_DIRECTION))
            return spi_csd_pkg::sel_direction;
        else if (a == `ADDR_OF(`IDX_PORT_DATA))
            return spi_csd_pkg::sel_port_data;
        else
            return spi_csd_pkg::sel_none;
    endfunction

    function automatic logic [4:0] half_period(input logic [1:0] rate);
        unique case (rate)
            2'h0: return `HALF_DIV2;
            2'h1: return `HALF_DIV4;
            2'h2: return `HALF_DIV16;
            2'h3: return `HALF_DIV32;
        endcase
    endfunction

    spi_csd_pkg::serial_control_type ctrl_r;
    spi_csd_pkg::xfer_state_type     state_r;
    spi_csd_pkg::reg_sel_type        sel;
    logic [7:0]  port_meta_r;
    logic [7:0]  port_sync_r;
    logic [7:0]  port_dir_r;
    logic [7:0]  port_data_r;
    logic [7:0]  shift_r;
    logic [7:0]  shift_nxt;
    logic [7:0]  rx_buf_r;
    logic [7:0]  status_val;
    logic [7:0]  spi_drv;
    logic [7:0]  spi_val;
    logic [7:0]  pin_drv;
    logic [7:0]  pin_val;
    logic [7:0]  dedicated;
    logic [31:0] prdata_r;
    logic [4:0]  div_cnt_r;
    logic [3:0]  edge_cnt_r;
    logic        tc_r;
    logic        write_collision_flag_r;
    logic        mode_fault_flag_r;
    logic        tc_arm_r;
    logic        write_collision_flag_arm_r;
    logic        mode_fault_flag_arm_r;
    logic        sck_m_r;
    logic        sck_prev_r;
    logic        sample_r;
    logic        out_r;
    logic        access;
    logic        wr_ctrl;
    logic        rd_status;
    logic        wr_data;
    logic        data_acc;
    logic        wr_blocked;
    logic        busy;
    logic        collide;
    logic        load;
    logic        start;
    logic        fault;
    logic        ss_in;
    logic        rx_in;
    logic        slave_active;
    logic        tick;
    logic        ev;
    logic        leading;
    logic        trailing;
    logic        done;

    // ****************************************
    // apb slave
    // ****************************************
    assign sel       = decode(paddr);
    assign access    = psel & penable;
    assign wr_ctrl   = access & pwrite & (sel == spi_csd_pkg::sel_control);
    assign rd_status = access & ~pwrite & (sel == spi_csd_pkg::sel_status);
    assign data_acc  = access & (sel == spi_csd_pkg::sel_data);
    assign wr_data   = data_acc & pwrite;
    // zero wait states keep the status-then-data clearing sequence simple
    assign pready    = 1'b1;
    assign pslverr   = access & (sel == spi_csd_pkg::sel_none);
    assign prdata    = prdata_r;

    assign status_val = {tc_r, write_collision_flag_r, 1'b0, mode_fault_flag_r, 4'h0};

    // read data captured in the setup phase, so the status value the arm logic sees is the one returned
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            prdata_r <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
        begin
            unique case (sel)
                spi_csd_pkg::sel_control:   prdata_r <= {24'h00_0000, ctrl_r};
                spi_csd_pkg::sel_status:    prdata_r <= {24'h00_0000, status_val};
                // reads come from the receive buffer
                spi_csd_pkg::sel_data:      prdata_r <= {24'h00_0000, rx_buf_r};
                spi_csd_pkg::sel_direction: prdata_r <= {24'h00_0000, port_dir_r};
                spi_csd_pkg::sel_port_data: prdata_r <= {24'h00_0000, port_data_r};
                spi_csd_pkg::sel_none:      prdata_r <= 32'h0000_0000;
            endcase
        end
    end

    // ****************************************
    // pin synchronisers
    // ****************************************
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            port_meta_r <= 8'hFF;
            port_sync_r <= 8'hFF;
        end
        else
        begin
            port_meta_r <= port_in;
            port_sync_r <= port_meta_r;
        end
    end

    assign ss_in = port_sync_r[`PIN_SS];
    assign rx_in = ctrl_r.master_select ? port_sync_r[`PIN_MISO] : port_sync_r[`PIN_MOSI];

    // ****************************************
    // control and port registers
    // ****************************************
    // pin 5 as plain output in master mode disarms the fault detector
    assign fault = ctrl_r.serial_system_enable & ctrl_r.master_select
                 & ~port_dir_r[`PIN_SS] & ~ss_in;

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            ctrl_r <= `CTRL_RESET;
        else
        begin
            // control bits written as a whole
            if (wr_ctrl)
                ctrl_r <= spi_csd_pkg::serial_control_type'(pwdata[7:0]);
            if (fault)
                ctrl_r.master_select <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            port_dir_r <= `DIR_RESET;
        else if (fault)
            port_dir_r <= {port_dir_r[7:6], 4'h0, port_dir_r[1:0]};
        else if (access && pwrite && sel == spi_csd_pkg::sel_direction)
            port_dir_r <= pwdata[7:0];
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            port_data_r <= `PORT_DATA_RESET;
        else if (access && pwrite && sel == spi_csd_pkg::sel_port_data)
            port_data_r <= pwdata[7:0];
    end

    // ****************************************
    // status flags
    // ****************************************
    // blocked until status read with the flag set
    assign wr_blocked = tc_r & ~tc_arm_r;
    assign busy       = (state_r != spi_csd_pkg::st_idle);
    assign collide    = wr_data & ~wr_blocked & busy;
    assign load       = wr_data & ~wr_blocked & ~busy;
    assign start      = load & ctrl_r.master_select & ctrl_r.serial_system_enable;

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tc_arm_r   <= 1'b0;
            write_collision_flag_arm_r <= 1'b0;
            mode_fault_flag_arm_r <= 1'b0;
        end
        else
        begin
            if (rd_status)
            begin
                tc_arm_r   <= prdata_r[`STAT_TC_BIT];
                write_collision_flag_arm_r <= 1'b1;
                mode_fault_flag_arm_r <= 1'b1;
            end
            else if (data_acc)
            begin
                tc_arm_r   <= 1'b0;
                write_collision_flag_arm_r <= 1'b0;
            end
            if (wr_ctrl)
                mode_fault_flag_arm_r <= 1'b0;
        end
    end

    // a new event in the clearing cycle wins over the clear
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            tc_r <= 1'(`STATUS_RESET >> `STAT_TC_BIT);
        else if (done)
            tc_r <= 1'b1;
        else if (data_acc && tc_arm_r)
            tc_r <= 1'b0;
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            write_collision_flag_r <= 1'b0;
        else if (collide)
            write_collision_flag_r <= 1'b1;
        else if (data_acc && write_collision_flag_arm_r)
            write_collision_flag_r <= 1'b0;
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            mode_fault_flag_r <= 1'b0;
        else if (fault)
            mode_fault_flag_r <= 1'b1;
        else if (wr_ctrl && mode_fault_flag_arm_r)
            mode_fault_flag_r <= 1'b0;
    end

    // request gated by enable and processor mask
    assign irq = ctrl_r.serial_irq_enable & (tc_r | mode_fault_flag_r) & ~cpu_irq_mask;

    // ****************************************
    // transfer sequencing
    // ****************************************
    assign slave_active = ctrl_r.serial_system_enable & ~ctrl_r.master_select & ~ss_in;
    assign tick         = (state_r == spi_csd_pkg::st_master) && (div_cnt_r == 5'h01);
    assign ev           = tick | (slave_active & (port_sync_r[`PIN_SCK] != sck_prev_r));
    assign leading      = ev & ~edge_cnt_r[0];
    assign trailing     = ev & edge_cnt_r[0];
    assign done         = trailing & (edge_cnt_r == `EDGE_LAST);

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            state_r <= spi_csd_pkg::st_idle;
        else
        begin
            unique case (state_r)
                spi_csd_pkg::st_idle:
                    if (start)
                        state_r <= spi_csd_pkg::st_master;
                    else if (slave_active && (!ctrl_r.clock_phase || leading))
                        state_r <= spi_csd_pkg::st_slave;
                spi_csd_pkg::st_master:
                    if (done || fault || !ctrl_r.serial_system_enable)
                        state_r <= spi_csd_pkg::st_idle;
                // phase zero slave stays busy until select rises
                spi_csd_pkg::st_slave:
                    if (!slave_active || (done && ctrl_r.clock_phase))
                        state_r <= spi_csd_pkg::st_idle;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            div_cnt_r <= `HALF_DIV2;
        else if (start || tick)
            div_cnt_r <= half_period(ctrl_r.clock_rate_field);
        else if (state_r == spi_csd_pkg::st_master)
            div_cnt_r <= div_cnt_r - 5'h01;
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            edge_cnt_r <= 4'h0;
        else if (start || (!slave_active && state_r != spi_csd_pkg::st_master))
            edge_cnt_r <= 4'h0;
        else if (ev)
            edge_cnt_r <= edge_cnt_r + 4'h1;
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            sck_prev_r <= 1'b1;
        else
            sck_prev_r <= port_sync_r[`PIN_SCK];
    end

    // master clock rests at the polarity level
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            sck_m_r <= 1'b0;
        else if (state_r != spi_csd_pkg::st_master)
            sck_m_r <= ctrl_r.clock_polarity;
        else if (tick)
            sck_m_r <= ~sck_m_r;
    end

    // ****************************************
    // shifter and receive buffer
    // ****************************************
    // msb first, receive fills from the bottom
    always_comb
    begin
        if (ctrl_r.clock_phase)
            shift_nxt = {shift_r[6:0], rx_in};
        else
            shift_nxt = {shift_r[6:0], sample_r};
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            shift_r <= 8'h00;
        // transmit byte goes straight into the shifter
        else if (load)
            shift_r <= pwdata[7:0];
        else if (trailing)
            shift_r <= shift_nxt;
    end

    // phase zero samples on the leading edge, phase one on the trailing edge
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            sample_r <= 1'b0;
        else if (leading && !ctrl_r.clock_phase)
            sample_r <= rx_in;
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            out_r <= 1'b0;
        else if (load)
            out_r <= pwdata[7];
        else if (leading && ctrl_r.clock_phase)
            out_r <= shift_r[7];
        else if (trailing && !ctrl_r.clock_phase)
            out_r <= shift_r[6];
        else if (!busy && !ev)
            out_r <= shift_r[7];
    end

    // received byte copied at completion; an uncleared flag is simply overwritten
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            rx_buf_r <= 8'h00;
        else if (done)
            rx_buf_r <= shift_nxt;
    end

    // ****************************************
    // port pins
    // ****************************************
    always_comb
    begin
        spi_drv = 8'h00;
        spi_val = 8'h00;
        dedicated = 8'h00;
        // enable takes pins 2 to 5
        if (ctrl_r.serial_system_enable)
        begin
            dedicated[`PIN_MISO] = 1'b1;
            dedicated[`PIN_MOSI] = 1'b1;
            dedicated[`PIN_SCK]  = 1'b1;
            // pin 5 as plain output in master mode
            dedicated[`PIN_SS]   = ~(ctrl_r.master_select & port_dir_r[`PIN_SS]);
        end
        // outputs only drive when their direction bit is set
        spi_drv[`PIN_MISO] = ~ctrl_r.master_select & ~ss_in & port_dir_r[`PIN_MISO];
        spi_val[`PIN_MISO] = out_r;
        spi_drv[`PIN_MOSI] = ctrl_r.master_select & port_dir_r[`PIN_MOSI];
        spi_val[`PIN_MOSI] = out_r;
        spi_drv[`PIN_SCK]  = ctrl_r.master_select & port_dir_r[`PIN_SCK];
        spi_val[`PIN_SCK]  = sck_m_r;
    end

    genvar i;
    generate
        for (i = 0; i < 8; i++)
        begin : g_pin
            assign pin_val[i] = dedicated[i] ? spi_val[i] : port_data_r[i];
            assign pin_drv[i] = dedicated[i] ? spi_drv[i] : port_dir_r[i];
        end
    endgenerate

    // open-drain lets high levels float on every port pin
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            port_drive.port_out <= 8'h00;
            port_drive.port_oe  <= 8'h00;
        end
        else
        begin
            port_drive.port_out <= pin_val;
            port_drive.port_oe  <= pin_drv & ~({8{ctrl_r.port_open_drain_select}} & pin_val);
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    chk_irq_request: assert property (@(posedge core_clk) disable iff (!rst_b)
        $rose(tc_r) && ctrl_r.serial_irq_enable && !cpu_irq_mask |-> irq)
        else $error("interrupt not raised on completion");

    chk_pin_release: assert property (@(posedge core_clk) disable iff (!rst_b)
        !$past(ctrl_r.serial_system_enable) && !$past(port_dir_r[`PIN_SCK]) |-> !port_drive.port_oe[`PIN_SCK])
        else $error("clock pin driven while released");

    chk_ss_gp_output: assert property (@(posedge core_clk) disable iff (!rst_b)
        ctrl_r.master_select && port_dir_r[`PIN_SS] && !mode_fault_flag_r |=> !mode_fault_flag_r)
        else $error("fault raised with select pin as output");

    chk_open_drain: assert property (@(posedge core_clk) disable iff (!rst_b)
        $past(ctrl_r.port_open_drain_select) |-> (port_drive.port_oe & port_drive.port_out) == 8'h00)
        else $error("open-drain pin driven high");

    chk_idle_clock: assert property (@(posedge core_clk) disable iff (!rst_b)
        state_r == spi_csd_pkg::st_idle |=> state_r != spi_csd_pkg::st_idle || sck_m_r == $past(ctrl_r.clock_polarity))
        else $error("idle clock not at polarity level");

    chk_rate_divide: assert property (@(posedge core_clk) disable iff (!rst_b)
        state_r == spi_csd_pkg::st_master && ctrl_r.clock_rate_field == 2'h1 && tick |=> !tick)
        else $error("clock half period too short");

    chk_complete_set: assert property (@(posedge core_clk) disable iff (!rst_b)
        done |=> tc_r && rx_buf_r == $past(shift_nxt))
        else $error("completion not flagged");

    chk_tc_clear: assert property (@(posedge core_clk) disable iff (!rst_b)
        $fell(tc_r) |-> $past(data_acc) && $past(tc_arm_r))
        else $error("complete flag cleared without sequence");

    chk_write_blocked: assert property (@(posedge core_clk) disable iff (!rst_b)
        wr_data && tc_r && !tc_arm_r && !busy && !ev |=> shift_r == $past(shift_r))
        else $error("blocked write reached the shifter");

    chk_write_collision_flag_clear: assert property (@(posedge core_clk) disable iff (!rst_b)
        $fell(write_collision_flag_r) |-> $past(data_acc) && $past(write_collision_flag_arm_r))
        else $error("collision flag cleared without sequence");

    chk_mode_fault_flag_clear: assert property (@(posedge core_clk) disable iff (!rst_b)
        $fell(mode_fault_flag_r) |-> $past(wr_ctrl) && $past(mode_fault_flag_arm_r))
        else $error("fault flag cleared without sequence");

    chk_status_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
        rd_status |-> prdata_r[5] == 1'b0 && prdata_r[3:0] == 4'h0)
        else $error("unused status bits not zero");

    chk_slave_no_start: assert property (@(posedge core_clk) disable iff (!rst_b)
        load && !ctrl_r.master_select |=> state_r != spi_csd_pkg::st_master)
        else $error("slave started a transfer");

    chk_collision_flag: assert property (@(posedge core_clk) disable iff (!rst_b)
        collide |=> write_collision_flag_r && state_r != spi_csd_pkg::st_idle || $past(done))
        else $error("collision not flagged");

    chk_mode_fault: assert property (@(posedge core_clk) disable iff (!rst_b)
        fault |=> mode_fault_flag_r && !ctrl_r.master_select && port_dir_r[5:2] == 4'h0)
        else $error("mode fault not handled");

endmodule

// >>> rtl/spi_csd_defs.svh
// register offsets, field positions, reset values and timing counts of the serial block
//
// Operation
// - irq on complete or fault when enabled
// - enable hands port pins 2-5 over
// - master with pin-5 direction: plain output
// - wired-OR bit makes whole port open-drain
// - master select: 0 slave, 1 master
// - master clock idles at polarity level
// - phase picks protocol; phase resets to one
// - rate field divides bus clock 2/4/16/32
// - byte end sets transfer complete flag
// - complete clears: status read, then data access
// - data writes ignored until status read
// - collision clears: status read, then data access
// - fault clears: status read, then control write
// - unused status bits read zero
// - only master data write starts a byte
// - receive buffered, transmit goes to shifter
// - write while busy flags collision, dropped
// - select low in master: fault, drop drivers
// - eight clock cycles move one byte
`ifndef SPI_CSD_DEFS_SVH
`define SPI_CSD_DEFS_SVH

`define IDX_SERIAL_CONTROL 16'h1028
`define IDX_SERIAL_STATUS 16'h1029
`define IDX_SERIAL_DATA 16'h102A
`define IDX_PORT_DIRECTION 16'h102B
`define IDX_PORT_DATA 16'h102C
`define ADDR_OF(idx) 16'((idx) * 16'h0004)

`define STAT_TC_BIT 7
`define STAT_WRITE_COLLISION_FLAG_BIT 6
`define STAT_MODE_FAULT_FLAG_BIT 4

`define PIN_MISO 2
`define PIN_MOSI 3
`define PIN_SCK 4
`define PIN_SS 5

`define CTRL_RESET 8'h04
`define STATUS_RESET 8'h00
`define DIR_RESET 8'h00
`define PORT_DATA_RESET 8'h00

`define HALF_DIV2 5'h01
`define HALF_DIV4 5'h02
`define HALF_DIV16 5'h08
`define HALF_DIV32 5'h10
`define EDGE_LAST 4'hF

`endif

// >>> rtl/spi_csd_pkg.sv
// types shared by the serial control, status and data block
package spi_csd_pkg;

    typedef struct packed {
        logic       serial_irq_enable;
        logic       serial_system_enable;
        logic       port_open_drain_select;
        logic       master_select;
        logic       clock_polarity;
        logic       clock_phase;
        logic [1:0] clock_rate_field;
    } serial_control_type;

    typedef struct packed {
        logic [7:0] port_out;
        logic [7:0] port_oe;
    } port_drive_type;

    typedef enum logic [2:0] {
        sel_none,
        sel_control,
        sel_status,
        sel_data,
        sel_direction,
        sel_port_data
    } reg_sel_type;

    typedef enum logic [1:0] {
        st_idle,
        st_master,
        st_slave
    } xfer_state_type;

endpackage

// >>> verif/serial_slave_model.sv
// behavioural far-side serial slave, phase one, polarity zero
`timescale 1ns/1ps
module serial_slave_model
(
    input  wire logic       sck,
    input  wire logic       mosi,
    input  wire logic       load,
    input  wire logic [7:0] tx_byte,
    output logic            miso,
    output logic [7:0]      rx_byte
);
    logic [7:0] sh_r;
    initial miso = 1'b1;
    always @(posedge sck or posedge load)
    begin
        if (load)
            sh_r <= tx_byte;
        else
        begin
            miso <= sh_r[7];
            sh_r <= {sh_r[6:0], 1'b0};
        end
    end
    always @(negedge sck)
        rx_byte <= {rx_byte[6:0], mosi};
endmodule

// >>> verif/spi_csd_bench.sv
// self-checking bench of the serial control, status and data block
`timescale 1ns/1ps
`include "spi_csd_defs.svh"
module spi_csd_bench;
    localparam logic [15:0] a_ctl = `ADDR_OF(`IDX_SERIAL_CONTROL);
    localparam logic [15:0] a_sts = `ADDR_OF(`IDX_SERIAL_STATUS);
    localparam logic [15:0] a_dat = `ADDR_OF(`IDX_SERIAL_DATA);
    localparam logic [15:0] a_dir = `ADDR_OF(`IDX_PORT_DIRECTION);
    logic                        core_clk, rst_b, psel, penable, pwrite, pready, pslverr;
    logic                        cpu_irq_mask, irq, ss_b, load, sck_w, mosi_w, miso;
    logic                        err, ext_sck, ext_mosi;
    logic [15:0]                 paddr;
    logic [31:0]                 pwdata, prdata, q;
    logic [7:0]                  d, t, rx;
    int                          n, r, cyc, miscompares, checks_done;
    spi_csd_pkg::port_drive_type pd;
    // released pins follow the bench's own master: clock idles low, data high
    assign sck_w  = pd.port_oe[4] ? pd.port_out[4] : ext_sck;
    assign mosi_w = pd.port_oe[3] ? pd.port_out[3] : ext_mosi;
    spi_csd spi_csd_inst (.core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cpu_irq_mask(cpu_irq_mask), .irq(irq),
        .port_in({2'b11, ss_b, sck_w, mosi_w, miso, 2'b11}), .port_drive(pd));
    serial_slave_model serial_slave_model_inst (.sck(sck_w), .mosi(mosi_w), .load(load),
        .tx_byte(t), .miso(miso), .rx_byte(rx));
    always #25 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            miscompares++;
            complete_run;
        end
    end
    // ****
    // bus tasks
    // ****
    function automatic int half(input int k);
        return k == 0 ? 1 : k == 1 ? 2 : k == 2 ? 8 : 16;
    endfunction
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        checks_done++;
        if (s !== e)
        begin
            miscompares++;
            $display("ERROR %0t: got %h want %h", $time, s, e);
        end
    endtask
    task automatic apb(input logic w, input logic [15:0] a, input logic [7:0] v);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, v};
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chk(q[7:0], e);
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        apb(1'b1, a, v);
    endtask
    task automatic xfer(input logic [7:0] v);
        wr(a_dat, v);
        n = 0;
        while (irq !== 1'b1 && n < 2000)
        begin
            @(posedge core_clk);
            n++;
        end
    endtask
    task automatic complete_run;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // ****
    // main sequence
    // ****
    initial
    begin
        {core_clk, rst_b, psel, penable, pwrite, paddr, pwdata, cpu_irq_mask, load, t, ext_sck} = '0;
        {ss_b, cyc, miscompares, checks_done} = '0;
        {ss_b, ext_mosi} = 2'b11;
        void'($urandom(8));
        repeat (8) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        rd(a_ctl, 8'h04);
        rd(a_sts, 8'h00);
        apb(1'b0, 16'h0000, 8'h00);
        chk({7'h0, err}, 8'h01);
        chk(q[7:0], 8'h00);
        wr(a_dir, 8'h18);
        for (r = 0; r < 4; r++)
        begin
            d = 8'($urandom);
            t <= 8'($urandom);
            load <= 1'b1;
            @(posedge core_clk);
            load <= 1'b0;
            wr(a_ctl, 8'hD4 | 8'(r));
            xfer(d);
            chk({7'h0, n >= 16 * half(r) - 2 && n <= 16 * half(r) + 4}, 8'h01);
            cpu_irq_mask <= 1'b1;
            @(posedge core_clk);
            chk({7'h0, irq}, 8'h00);
            cpu_irq_mask <= 1'b0;
            if (r == 0) wr(a_dat, ~d);
            rd(a_sts, 8'h80);
            chk(rx, d);
            apb(1'b0, a_dat, 8'h00);
            // two-stage pin sync limits receive at the fast rates
            if (r > 1) chk(q[7:0], t);
            rd(a_sts, 8'h00);
            $display("rate %0d done", r);
        end
        wr(a_dat, d);
        repeat (20) @(posedge core_clk);
        xfer(~d);
        rd(a_sts, 8'hC0);
        chk(rx, d);
        apb(1'b0, a_dat, 8'h00);
        rd(a_sts, 8'h00);
        $display("collision done");
        wr(a_dir, 8'h38);
        ss_b <= 1'b0;
        repeat (6) @(posedge core_clk);
        rd(a_sts, 8'h00);
        wr(a_dir, 8'h18);
        repeat (6) @(posedge core_clk);
        chk({7'h0, irq}, 8'h01);
        rd(a_sts, 8'h10);
        rd(a_ctl, 8'hC7);
        rd(a_dir, 8'h00);
        ss_b <= 1'b1;
        wr(a_ctl, 8'h5C);
        rd(a_sts, 8'h00);
        wr(a_dir, 8'h18);
        @(posedge core_clk);
        chk({7'h0, sck_w}, 8'h01);
        wr(a_ctl, 8'h7C);
        @(posedge core_clk);
        chk({7'h0, pd.port_oe[4]}, 8'h00);
        wr(a_ctl, 8'hC4);
        wr(a_dat, d);
        repeat (40) @(posedge core_clk);
        chk({7'h0, irq}, 8'h00);
        $display("fault and slave done");
        // phase zero, select low for one byte
        wr(a_ctl, 8'hC0);
        d = 8'($urandom);
        ss_b <= 1'b0;
        for (r = 7; r >= 0; r--)
        begin
            ext_mosi <= d[r];
            repeat (4) @(posedge core_clk);
            ext_sck <= 1'b1;
            repeat (4) @(posedge core_clk);
            ext_sck <= 1'b0;
        end
        repeat (6) @(posedge core_clk);
        chk({7'h0, irq}, 8'h01);
        ss_b <= 1'b1;
        rd(a_sts, 8'h80);
        apb(1'b0, a_dat, 8'h00);
        chk(q[7:0], d);
        $display("slave phase zero done");
        complete_run;
    end
endmodule
